// *** hdl/psc_code_cmp.sv ***
`timescale 1ns/100ps

// --------------------------------------------------------------
// Code comparator, registered to keep the wide compare off the path
// --------------------------------------------------------------
module psc_code_cmp (
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    // Operands
    input  wire psc_pkg::psc_code_t a_i,
    input  wire psc_pkg::psc_code_t b_i,
    // Result
    output      logic              match_o
);
    import psc_pkg::*;

    logic match_q;

    // Compare registered one cycle after operands settle
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= (a_i == b_i);
        end
    end

    assign match_o = match_q;
endmodule // psc_code_cmp

// *** hdl/psc_handler.sv ***
// Overview of operation
// - Disable: P1 zero uses code; b8 set selects alternate key b5..b1; P1=1 and b7..b6 refused
// - Disable and enable carry Lc 08 with eight-byte code; enable needs P1 00
// - Low three bits of P2 pick the code slot acted on
// - Re-enabling a replaced code sets the alternate usage qualifier to 00
// - Successful disable or enable pulses a security environment revalidation request
// - Enable refused when code already enabled or blocked
// - Enable with correct code restores counter to 3 and enables
// - Enable with wrong code decrements counter, code stays disabled
// - Third consecutive wrong code blocks it; only recovery unblocks
// - Blocked disabled code grants access; blocked enabled code denies it
// - Recovery accepted whether or not code blocked, only while key unblocked
// - Correct key stores new code, key counter 10, code counter 3, enabled
// - Wrong key decrements the slot's own key counter, answers 63C9 down to 63C1
// - Tenth wrong key blocks it, answers 63C0; later recoveries with Lc 10 answer 6983
// - Wrong key leaves code counter, blocked and enabled unchanged
// - Empty recovery returns remaining key tries as 63CX
// - Empty recovery on blocked key answers 63C0
// - Recovery: P1 00, Lc absent or 10, key then new code
// - Disable: correct restores 3 and disables; wrong decrements, stays enabled
// - Disable refused when code already disabled or blocked
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "psc_consts.svh"

module psc_handler (
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 reset_i,
    // Command request
    input  wire logic                 cmd_valid_i,
    input  wire psc_pkg::psc_cmd_s    cmd_i,
    // Command answer
    output      logic                 done_o,
    output      logic [15:0]          sw_o,
    output      logic                 se_revalidate_o,
    // Usage template and access state
    output      logic [7:0]           alt_usage_o,
    output      logic [4:0]           alt_ref_o,
    output      logic [`PSC_SLOTS-1:0] access_granted_o,
    output      logic                 busy_o,
    // Register port
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [31:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output      logic [31:0]          reg_rdata_o
);
    import psc_pkg::*;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SLOT   = 8'h08;

    psc_state_e  state_q;
    psc_cmd_s    cmd_q;
    psc_slot_s   rd_slot;
    psc_slot_s   wr_slot_d;
    logic        wr_en_d;
    logic        match;
    logic        cmp_wait_q;
    logic        done_q;
    logic [15:0] sw_q;
    logic        se_q;
    logic [7:0]  alt_usage_q;
    logic [4:0]  alt_ref_q;
    logic        grant_to_blocked_q;
    logic [`PSC_SLOTS-1:0] access_q;
    logic [`PSC_SLOT_W-1:0] view_idx_q;
    logic [31:0] rdata_q;
    logic [15:0] sw_d;
    logic        se_d;
    logic        usage_clr_d;
    logic        usage_set_d;
    logic [`PSC_SLOT_W-1:0] idx;
    psc_code_t   cmp_ref;

    // Slot selected by the reference number in P2
    assign idx = cmd_q.p2[`PSC_SLOT_W-1:0];

    // --------------------------------------------------------------
    // Storage and comparator
    // --------------------------------------------------------------
    psc_slot_store u_store (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .wr_en_i   (wr_en_d),
        .wr_idx_i  (idx),
        .wr_data_i (wr_slot_d),
        .rd_idx_i  (state_q == PSC_IDLE ? view_idx_q : idx),
        .rd_data_o (rd_slot)
    );

    // Recovery compares against the key, the others against the code
    assign cmp_ref = (cmd_q.op == `PSC_OP_RECOVER) ? rd_slot.key : rd_slot.value;

    psc_code_cmp u_cmp (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .a_i       (cmp_ref),
        .b_i       (cmd_q.first),
        .match_o   (match)
    );

    // --------------------------------------------------------------
    // Sequencer: latch, wait one cycle for compare, execute
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q    <= PSC_IDLE;
            cmd_q      <= '0;
            cmp_wait_q <= 1'b0;
        end else begin
            case (state_q)
                PSC_IDLE: begin
                    if (cmd_valid_i) begin
                        cmd_q      <= cmd_i;
                        cmp_wait_q <= 1'b1;
                        state_q    <= PSC_EXEC;
                    end
                end
                PSC_EXEC: begin
                    if (cmp_wait_q) begin
                        cmp_wait_q <= 1'b0;
                    end else begin
                        state_q <= PSC_DONE;
                    end
                end
                PSC_DONE: begin
                    state_q <= PSC_IDLE;
                end
                default: begin
                    state_q <= PSC_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Command decision: status word and slot update
    // --------------------------------------------------------------
    always_comb begin
        logic exec;
        logic is_dis;
        logic p1_ok;
        logic lc_ok;
        exec        = (state_q == PSC_EXEC) && !cmp_wait_q;
        is_dis      = (cmd_q.op == `PSC_OP_DISABLE);
        wr_slot_d   = rd_slot;
        wr_en_d     = 1'b0;
        sw_d        = `PSC_SW_OK;
        se_d        = 1'b0;
        usage_clr_d = 1'b0;
        usage_set_d = 1'b0;
        p1_ok       = 1'b0;
        lc_ok       = 1'b0;
        // Parameter checks
        if (is_dis) begin
            p1_ok = (cmd_q.p1 != `PSC_P1_RESERVED)
                 && !cmd_q.p1[`PSC_P1_RFU_HI] && !cmd_q.p1[`PSC_P1_RFU_LO]
                 && (cmd_q.p1[`PSC_P1_ALT_BIT] || cmd_q.p1 == `PSC_P1_PLAIN);
        end else begin
            p1_ok = (cmd_q.p1 == `PSC_P1_PLAIN);
        end
        if (cmd_q.op == `PSC_OP_RECOVER) begin
            lc_ok = (cmd_q.lc == `PSC_LC_EMPTY) || (cmd_q.lc == `PSC_LC_RECOVER);
        end else begin
            lc_ok = (cmd_q.lc == `PSC_LC_CODE);
        end
        if (!exec) begin
            sw_d = `PSC_SW_OK;
        end else if (cmd_q.op > `PSC_OP_RECOVER || !p1_ok) begin
            sw_d = `PSC_SW_BAD_P1P2;
        end else if (!lc_ok) begin
            sw_d = `PSC_SW_BAD_LEN;
        end else if (cmd_q.op == `PSC_OP_RECOVER) begin
            if (cmd_q.lc == `PSC_LC_EMPTY) begin
                // Blocked key reads as zero tries
                sw_d = {`PSC_SW_TRIES_BASE, rd_slot.key_tries};
            end else if (rd_slot.key_tries == `PSC_TRIES_ZERO) begin
                sw_d = `PSC_SW_KEY_BLOCKED;
            end else if (match) begin
                wr_slot_d.value     = cmd_q.second;
                wr_slot_d.key_tries = `PSC_KEY_TRIES;
                wr_slot_d.tries     = `PSC_CODE_TRIES;
                wr_slot_d.enabled   = 1'b1;
                wr_slot_d.blocked   = 1'b0;
                wr_en_d             = 1'b1;
                if (rd_slot.alt_used) begin
                    // Recovery re-enables the code, so the replacement must stop as well
                    wr_slot_d.alt_used = 1'b0;
                    usage_clr_d        = 1'b1;
                end
            end else begin
                // Only the key counter moves; code state untouched
                wr_slot_d.key_tries = rd_slot.key_tries - `PSC_TRIES_ONE;
                wr_en_d             = 1'b1;
                sw_d = {`PSC_SW_TRIES_BASE, wr_slot_d.key_tries};
            end
        end else if (rd_slot.blocked || (rd_slot.enabled != is_dis)) begin
            sw_d = `PSC_SW_BAD_STATE;
        end else if (match) begin
            wr_slot_d.tries   = `PSC_CODE_TRIES;
            wr_slot_d.enabled = !is_dis;
            wr_en_d           = 1'b1;
            if (is_dis && cmd_q.p1[`PSC_P1_ALT_BIT]) begin
                wr_slot_d.alt_used = 1'b1;
                wr_slot_d.alt_ref  = cmd_q.p1[`PSC_REF_HI:0];
                usage_set_d        = 1'b1;
            end
            if (!is_dis && rd_slot.alt_used) begin
                wr_slot_d.alt_used = 1'b0;
                usage_clr_d        = 1'b1;
            end
            se_d = 1'b1;
        end else begin
            // Enabled flag kept as it was, counter decremented
            wr_slot_d.tries = rd_slot.tries - `PSC_TRIES_ONE;
            wr_en_d         = 1'b1;
            if (wr_slot_d.tries == `PSC_TRIES_ZERO) begin
                wr_slot_d.blocked = 1'b1;
            end
            sw_d = {`PSC_SW_TRIES_BASE, wr_slot_d.tries};
        end
    end

    // --------------------------------------------------------------
    // Answer outputs
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            done_q <= 1'b0;
            sw_q   <= `PSC_SW_OK;
            se_q   <= 1'b0;
        end else begin
            done_q <= (state_q == PSC_EXEC) && !cmp_wait_q;
            se_q   <= se_d;
            if ((state_q == PSC_EXEC) && !cmp_wait_q) begin
                sw_q <= sw_d;
            end
        end
    end

    // Usage template for the alternate global reference
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            alt_usage_q <= `PSC_USAGE_NONE;
            alt_ref_q   <= '0;
        end else if (usage_set_d) begin
            alt_usage_q <= `PSC_USAGE_USE;
            alt_ref_q   <= cmd_q.p1[`PSC_REF_HI:0];
        end else if (usage_clr_d) begin
            alt_usage_q <= `PSC_USAGE_NONE;
        end
    end

    // Access condition per slot; a blocked code stays as left
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            access_q <= '0;
        end else if (wr_en_d) begin
            access_q[idx] <= !wr_slot_d.enabled
                          || (match && !wr_slot_d.blocked && wr_slot_d.enabled);
        end
    end

    // --------------------------------------------------------------
    // Register port: control and status view
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            view_idx_q         <= '0;
            grant_to_blocked_q <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
            view_idx_q         <= reg_wdata_i[`PSC_SLOT_W-1:0];
            grant_to_blocked_q <= reg_wdata_i[8];
        end
    end

    // Slot view is valid only while idle; busy tells software so
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rdata_q <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CTRL:   rdata_q <= {23'h0, grant_to_blocked_q, 5'h0, view_idx_q};
                REG_STATUS: rdata_q <= {15'h0, state_q != PSC_IDLE, sw_q};
                REG_SLOT:   rdata_q <= {20'h0, rd_slot.key_tries, rd_slot.tries,
                                        2'h0, rd_slot.blocked, rd_slot.enabled};
                default:    rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign done_o           = done_q;
    assign sw_o             = sw_q;
    assign se_revalidate_o  = se_q;
    assign alt_usage_o      = alt_usage_q;
    assign alt_ref_o        = alt_ref_q;
    assign access_granted_o = access_q;
    assign busy_o           = (state_q != PSC_IDLE);
    assign reg_rdata_o      = rdata_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_ok_has_full;
        @(posedge clk_sys_i) disable iff (reset_i)
        (done_q && sw_q == `PSC_SW_OK)
        |-> (rd_slot.tries == `PSC_CODE_TRIES)
            && (cmd_q.op != `PSC_OP_RECOVER || rd_slot.key_tries == `PSC_KEY_TRIES);
    endproperty
    a_ok_has_full: assert property (p_ok_has_full) else $error("ok answer malformed");

    property p_done_latency;
        @(posedge clk_sys_i) disable iff (reset_i)
        (state_q == PSC_IDLE && cmd_valid_i) |-> ##3 done_q;
    endproperty
    a_done_latency: assert property (p_done_latency) else $error("answer not three cycles after request");

    property p_se_on_ok;
        @(posedge clk_sys_i) disable iff (reset_i)
        se_q |-> (done_q && sw_q == `PSC_SW_OK);
    endproperty
    a_se_on_ok: assert property (p_se_on_ok) else $error("revalidate without success");

    // Slot view follows the command's slot in the answer cycle
    property p_block_at_zero;
        @(posedge clk_sys_i) disable iff (reset_i)
        (done_q && cmd_q.op != `PSC_OP_RECOVER && sw_q == {`PSC_SW_TRIES_BASE, `PSC_TRIES_ZERO}) |-> rd_slot.blocked;
    endproperty
    a_block_at_zero: assert property (p_block_at_zero) else $error("code not blocked at zero tries");

    property p_key_block;
        @(posedge clk_sys_i) disable iff (reset_i)
        (done_q && cmd_q.op == `PSC_OP_RECOVER && cmd_q.p1 == `PSC_P1_PLAIN && cmd_q.lc == `PSC_LC_RECOVER
            && rd_slot.key_tries == `PSC_TRIES_ZERO)
        |-> (sw_q == {`PSC_SW_TRIES_BASE, `PSC_TRIES_ZERO} || sw_q == `PSC_SW_KEY_BLOCKED);
    endproperty
    a_key_block: assert property (p_key_block) else $error("blocked key answered wrongly");

    property p_wrong_key_keeps_code;
        @(posedge clk_sys_i) disable iff (reset_i)
        (done_q && cmd_q.op == `PSC_OP_RECOVER && cmd_q.lc == `PSC_LC_RECOVER
            && sw_q[15:4] == `PSC_SW_TRIES_BASE)
        |-> rd_slot.tries == $past(rd_slot.tries) && rd_slot.blocked == $past(rd_slot.blocked)
            && rd_slot.enabled == $past(rd_slot.enabled);
    endproperty
    a_wrong_key_keeps_code: assert property (p_wrong_key_keeps_code) else $error("wrong key moved code");
endmodule // psc_handler

// *** hdl/psc_slot_store.sv ***
`timescale 1ns/100ps
`include "psc_consts.svh"

// --------------------------------------------------------------
// Code slot storage: flip-flops, one write port, one read port
// --------------------------------------------------------------
module psc_slot_store (
    // Clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      reset_i,
    // Write port
    input  wire logic                      wr_en_i,
    input  wire logic [`PSC_SLOT_W-1:0]    wr_idx_i,
    input  wire psc_pkg::psc_slot_s        wr_data_i,
    // Read port
    input  wire logic [`PSC_SLOT_W-1:0]    rd_idx_i,
    output      psc_pkg::psc_slot_s        rd_data_o
);
    import psc_pkg::*;

    psc_slot_s mem_q [`PSC_SLOTS];

    // Each slot resets to an enabled code, full counters, zero values
    for (genvar g = 0; g < `PSC_SLOTS; g++) begin : g_slot
        always_ff @(posedge clk_sys_i) begin
            if (reset_i) begin
                mem_q[g]           <= '0;
                mem_q[g].tries     <= `PSC_CODE_TRIES;
                mem_q[g].enabled   <= 1'b1;
                mem_q[g].key_tries <= `PSC_KEY_TRIES;
            end else if (wr_en_i && wr_idx_i == g) begin
                mem_q[g] <= wr_data_i;
            end
        end
    end

    assign rd_data_o = mem_q[rd_idx_i];
endmodule // psc_slot_store

// *** shared/psc_consts.svh ***
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// Command opcodes (coined encoding on cmd_op)
`define PSC_OP_DISABLE      2'h0
`define PSC_OP_ENABLE       2'h1
`define PSC_OP_RECOVER      2'h2

// Parameter byte coding
`define PSC_P1_PLAIN        8'h00
`define PSC_P1_RESERVED     8'h01
`define PSC_P1_ALT_BIT      7
`define PSC_P1_RFU_HI       6
`define PSC_P1_RFU_LO       5
`define PSC_REF_HI          4
`define PSC_LC_CODE         8'h08
`define PSC_LC_RECOVER      8'h10
`define PSC_LC_EMPTY        8'h00

// Counter initial values, zero and decrement step
`define PSC_CODE_TRIES      4'h3
`define PSC_KEY_TRIES       4'hA
`define PSC_TRIES_ZERO      4'h0
`define PSC_TRIES_ONE       4'h1

// Usage qualifier values
`define PSC_USAGE_NONE      8'h00
`define PSC_USAGE_USE       8'h08

// Status words
`define PSC_SW_OK           16'h9000
`define PSC_SW_TRIES_BASE   12'h63C
`define PSC_SW_KEY_BLOCKED  16'h6983
`define PSC_SW_BAD_STATE    16'h6985
`define PSC_SW_BAD_P1P2     16'h6A86
`define PSC_SW_BAD_LEN      16'h6700
`define PSC_SW_NO_REF       16'h6A88

// Number of code slots held by the handler
`define PSC_SLOTS           8
`define PSC_SLOT_W          3

`endif

// *** shared/psc_pkg.sv ***
package psc_pkg;
    typedef logic [63:0] psc_code_t;

    // One command as presented by the transport layer
    typedef struct packed {
        logic [1:0]  op;
        logic [7:0]  p1;
        logic [7:0]  p2;
        logic [7:0]  lc;
        psc_code_t   first;
        psc_code_t   second;
    } psc_cmd_s;

    // Per-code state
    typedef struct packed {
        psc_code_t   value;
        logic [3:0]  tries;
        logic        enabled;
        logic        blocked;
        logic [4:0]  alt_ref;
        logic        alt_used;
        psc_code_t   key;
        logic [3:0]  key_tries;
    } psc_slot_s;

    typedef enum logic [1:0] {
        PSC_IDLE,
        PSC_EXEC,
        PSC_DONE
    } psc_state_e;
endpackage

// *** tb/psc_handler_bench.sv ***
`timescale 1ns/100ps
`include "psc_consts.svh"

module psc_handler_bench;
    import psc_pkg::*;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam logic [1:0] op_d = `PSC_OP_DISABLE;
    localparam logic [1:0] op_e = `PSC_OP_ENABLE;
    localparam logic [1:0] op_r = `PSC_OP_RECOVER;
    localparam psc_code_t  nc   = 64'h1234_5678_9abc_def0;
    logic                  clk_sys_i;
    logic                  reset_i;
    logic                  cmd_valid;
    psc_cmd_s              cmd_w;
    logic                  done;
    logic [15:0]           sw;
    logic                  se;
    logic [7:0]            usage;
    logic [4:0]            aref;
    logic [`PSC_SLOTS-1:0] access;
    logic                  busy;
    logic [7:0]            reg_addr;
    logic [31:0]           reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [31:0]           reg_rdata;
    logic [15:0]           sw_seen;
    logic                  se_seen;
    logic [31:0]           d;
    int                    bad_count;
    int                    checks_done;

    psc_handler dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd_w),
        .done_o(done), .sw_o(sw), .se_revalidate_o(se), .alt_usage_o(usage), .alt_ref_o(aref),
        .access_granted_o(access), .busy_o(busy), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));

    psc_term_model term (.clk_sys_i(clk_sys_i), .done_i(done), .sw_i(sw), .se_i(se),
        .cmd_valid_o(cmd_valid), .cmd_o(cmd_w));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Register port: one-cycle strobes, read data in the following cycle only
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk_sys_i);
        v = reg_rdata;
    endtask

    // Expected slot view word: key tries, code tries, blocked, enabled
    function automatic logic [31:0] sv(input logic [3:0] k, t, input logic b, en);
        sv = {20'h0_0000, k, t, 2'b00, b, en};
    endfunction

    task automatic slot(input logic [2:0] s, input logic [31:0] e);
        wr(8'h00, {29'h0, s});
        rd(8'h08, d);
        chk("slot", e, d);
    endtask

    task automatic cmd(input logic [1:0] op, input logic [7:0] p1, p2, lc, input psc_code_t a, b,
                       input logic [15:0] e);
        logic ok;
        term.issue(op, p1, p2, lc, a, b, sw_seen, se_seen, ok);
        chk("done", 32'h1, {31'h0, ok});
        chk("sw", {16'h0, e}, {16'h0, sw_seen});
    endtask

    task automatic tend(input string n);
        $display("test %s finished", n);
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Tests take about 300 cycles; the 20000-cycle limit, over sixty times that, means a hang
    initial begin
        #200000;
        bad_count++;
        conclude();
    end

    initial begin
        bad_count = 0;
        checks_done = 0;
        reset_i = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        // Reset state
        rd(8'h04, d);
        chk("status", {16'h0, 16'h9000}, d);
        rd(8'h0C, d);
        chk("unmapped", 32'h0, d);
        slot(0, sv(4'hA, 4'h3, 1'b0, 1'b1));
        chk("usage", 32'h0, {24'h0, usage});
        tend("reset");
        // Disable and enable on slot 0, code value zero
        cmd(op_e, 8'h00, 8'h00, 8'h08, 64'h0, 64'h0, 16'h6985);
        cmd(op_d, 8'h00, 8'h00, 8'h08, 64'h1, 64'h0, 16'h63C2);
        chk("se", 32'h0, {31'h0, se_seen});
        slot(0, sv(4'hA, 4'h2, 1'b0, 1'b1));
        cmd(op_d, 8'h00, 8'h00, 8'h08, 64'h0, 64'h0, 16'h9000);
        chk("se", 32'h1, {31'h0, se_seen});
        slot(0, sv(4'hA, 4'h3, 1'b0, 1'b0));
        cmd(op_d, 8'h00, 8'h00, 8'h08, 64'h0, 64'h0, 16'h6985);
        cmd(op_e, 8'h00, 8'h00, 8'h08, 64'h1, 64'h0, 16'h63C2);
        slot(0, sv(4'hA, 4'h2, 1'b0, 1'b0));
        cmd(op_e, 8'h00, 8'h00, 8'h08, 64'h0, 64'h0, 16'h9000);
        chk("se", 32'h1, {31'h0, se_seen});
        slot(0, sv(4'hA, 4'h3, 1'b0, 1'b1));
        tend("toggle");
        // Malformed parameters leave every counter alone
        cmd(op_d, 8'h01, 8'h00, 8'h08, 64'h1, 64'h0, 16'h6A86);
        cmd(op_d, 8'h40, 8'h00, 8'h08, 64'h1, 64'h0, 16'h6A86);
        cmd(op_d, 8'h00, 8'h00, 8'h07, 64'h1, 64'h0, 16'h6700);
        cmd(op_e, 8'h80, 8'h00, 8'h08, 64'h1, 64'h0, 16'h6A86);
        cmd(op_r, 8'h01, 8'h00, 8'h10, 64'h1, 64'h0, 16'h6A86);
        cmd(op_r, 8'h00, 8'h00, 8'h05, 64'h1, 64'h0, 16'h6700);
        cmd(2'h3, 8'h00, 8'h00, 8'h08, 64'h1, 64'h0, 16'h6A86);
        slot(0, sv(4'hA, 4'h3, 1'b0, 1'b1));
        tend("params");
        // Alternative key on slots 1 and 5
        cmd(op_d, 8'h85, 8'h01, 8'h08, 64'h0, 64'h0, 16'h9000);
        chk("usage", 32'h08, {24'h0, usage});
        chk("altref", 32'h05, {27'h0, aref});
        cmd(op_e, 8'h00, 8'h01, 8'h08, 64'h0, 64'h0, 16'h9000);
        chk("usage", 32'h00, {24'h0, usage});
        cmd(op_d, 8'h85, 8'h05, 8'h08, 64'h0, 64'h0, 16'h9000);
        cmd(op_r, 8'h00, 8'h05, 8'h10, 64'h0, 64'h0, 16'h9000);
        chk("usage_rec", 32'h00, {24'h0, usage});
        tend("alternative");
        // Block an enabled code (slot 2) and a disabled one (slot 3)
        for (int i = 0; i < 3; i++) begin
            cmd(op_d, 8'h00, 8'h02, 8'h08, 64'h1, 64'h0, {12'h63C, 4'(2 - i)});
        end
        slot(2, sv(4'hA, 4'h0, 1'b1, 1'b1));
        chk("access2", 32'h0, {31'h0, access[2]});
        cmd(op_d, 8'h00, 8'h02, 8'h08, 64'h0, 64'h0, 16'h6985);
        cmd(op_d, 8'h00, 8'h03, 8'h08, 64'h0, 64'h0, 16'h9000);
        for (int i = 0; i < 3; i++) begin
            cmd(op_e, 8'h00, 8'h03, 8'h08, 64'h1, 64'h0, {12'h63C, 4'(2 - i)});
        end
        slot(3, sv(4'hA, 4'h0, 1'b1, 1'b0));
        chk("access3", 32'h1, {31'h0, access[3]});
        cmd(op_e, 8'h00, 8'h03, 8'h08, 64'h0, 64'h0, 16'h6985);
        tend("block");
        // Recovery of the blocked slot 2
        cmd(op_r, 8'h00, 8'h02, 8'h00, 64'h0, 64'h0, 16'h63CA);
        cmd(op_r, 8'h00, 8'h02, 8'h10, 64'h1, nc, 16'h63C9);
        slot(2, sv(4'h9, 4'h0, 1'b1, 1'b1));
        cmd(op_r, 8'h00, 8'h02, 8'h10, 64'h0, nc, 16'h9000);
        slot(2, sv(4'hA, 4'h3, 1'b0, 1'b1));
        chk("busy", 32'h0, {31'h0, busy});
        cmd(op_d, 8'h00, 8'h02, 8'h08, 64'h0, 64'h0, 16'h63C2);
        cmd(op_d, 8'h00, 8'h02, 8'h08, nc, 64'h0, 16'h9000);
        tend("recover");
        // Exhaust the recovery key of slot 4
        for (int i = 0; i < 10; i++) begin
            cmd(op_r, 8'h00, 8'h04, 8'h10, 64'h1, nc, {12'h63C, 4'(9 - i)});
        end
        slot(4, sv(4'h0, 4'h3, 1'b0, 1'b1));
        cmd(op_r, 8'h00, 8'h04, 8'h10, 64'h0, nc, 16'h6983);
        slot(4, sv(4'h0, 4'h3, 1'b0, 1'b1));
        cmd(op_r, 8'h00, 8'h04, 8'h00, 64'h0, 64'h0, 16'h63C0);
        rd(8'h04, d);
        chk("status", {16'h0, 16'h63C0}, d);
        tend("keyblock");
        conclude();
    end
endmodule // psc_handler_bench

// *** tb/psc_term_model.sv ***
`timescale 1ns/100ps

// ------------------------------------------------------------
// Terminal model: one command at a time, bounded wait for done
// ------------------------------------------------------------
module psc_term_model (
    // Clock
    input  wire logic              clk_sys_i,
    // Answer from the handler
    input  wire logic              done_i,
    input  wire logic [15:0]       sw_i,
    input  wire logic              se_i,
    // Command to the handler
    output      logic              cmd_valid_o,
    output      psc_pkg::psc_cmd_s cmd_o
);
    import psc_pkg::*;

    // Quiet at time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
    end

    // Strobe one cycle, then show inverted fields so stale data never looks valid
    task automatic issue(input logic [1:0] op, input logic [7:0] p1, p2, lc, input psc_code_t a, b,
                         output logic [15:0] sw, output logic se, output logic ok);
        psc_cmd_s c;
        c.op     = op;
        c.p1     = p1;
        c.p2     = p2;
        c.lc     = lc;
        c.first  = a;
        c.second = b;
        ok = 1'b0;
        sw = 16'h0000;
        se = 1'b0;
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b1;
        cmd_o       <= c;
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b0;
        cmd_o       <= ~c;
        // Answer is due on the third edge; a few spare edges catch a late one
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clk_sys_i);
            if (done_i === 1'b1) begin
                ok = 1'b1;
                sw = sw_i;
                se = se_i;
            end
        end
    endtask
endmodule // psc_term_model
